// File: hdl/hif_top.sv
// Interrupt flags, enable mask and receive address filter of the HDLC.
module hif_top
  import hif_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [4:0] up_addr,
  input wire logic up_wr,
  input wire logic up_rd,
  input wire logic [7:0] up_wdata,
  output logic [7:0] up_rdata,
  input wire logic te_mode,
  input wire logic tx_enable,
  input wire logic addr_recog_enable,
  input wire hif_evt_type evt,
  input wire logic [4:0] tx_level,
  input wire logic [4:0] rx_level,
  input wire logic tx_packet_loaded,
  input wire logic rx_flag_seen,
  input wire logic [6:0] status_upper,
  input wire hif_byte_type rx_in,
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  output hif_byte_type rx_out,
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  output logic irq,
  output logic rx_enable,
  output logic tx_prio_high,
  output logic tx_abort
);

  logic [7:0] mask_q; // Interrupt enable mask.
  logic [7:0] arm1_q; // First address byte match register.
  logic [7:0] arm2_q; // Second address byte match register.
  logic [7:0] rdata_q; // Read data held for the processor.
  logic [7:0] flags_q; // Sticky interrupt flags.
  logic [7:0] set_v; // Flag set events this cycle.
  logic [7:0] flags_vis; // Flags as the processor sees them.
  logic [7:0] mask_eff; // Mask with the collision enable gated.
  logic pend; // Some enabled flag is pending.
  logic irq_q; // Registered interrupt request.
  logic rd_irq; // Read of the interrupt status register.
  logic rx_en_q; // Receiver enabled.
  logic prio_q; // High transmit access priority.
  logic abort_q; // Abort sequence request pulse.
  logic coll_set; // Collision seen this cycle.
  logic ovf_set; // Receive overflow this cycle.

  hif_filt_state_type st_q; // Address filter state.
  hif_filt_state_type st_d; // Next address filter state.
  hif_byte_type hold1_q; // First address byte held back.
  hif_byte_type hold2_q; // Second byte waiting for replay.
  logic replay_q; // Second byte still to be pushed.
  logic take; // Input byte accepted this cycle.
  logic cmp1; // First byte compare active.
  logic cmp2; // Second byte compare active.
  logic a1_ok; // First byte matches or is not compared.
  logic a2_ok; // Second byte matches or is broadcast.
  logic push_v; // Word offered to the buffer.
  hif_byte_type push_b; // Word offered to the buffer.
  logic buf_ready; // Buffer has room.

  // Processor writes: mask and status share an address.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= HIF_RST_MASK;
      arm1_q <= HIF_RST_ARM;
      arm2_q <= HIF_RST_ARM;
    end else if (up_wr) begin
      unique case (up_addr)
        HIF_ADDR_IRQ: mask_q <= up_wdata; // R1 R17
        HIF_ADDR_ARM1: arm1_q <= up_wdata;
        HIF_ADDR_ARM2: arm2_q <= up_wdata;
        default: begin
          // Other addresses belong to other blocks.
        end
      endcase
    end
  end

  // Collision enable only counts in terminal mode.
  assign mask_eff = {mask_q[HIF_BIT_COLL] & te_mode, mask_q[6:0]}; // R2 R1

  // Collision in NT mode always reads zero.
  assign flags_vis = {flags_q[HIF_BIT_COLL] & te_mode, flags_q[6:0]}; // R3

  // Echo mismatch while transmitting in terminal mode.
  assign coll_set = te_mode & tx_enable & evt.echo_valid
    & (evt.echo_bit != evt.d_bit); // R3

  // A byte pushed into a full receive FIFO.
  assign ovf_set = evt.rx_push & (rx_level == HIF_FIFO_DEPTH); // R10

  // Gather the flag set events.
  always_comb begin
    set_v = 8'h00;
    set_v[HIF_BIT_COLL] = coll_set; // R3
    set_v[HIF_BIT_RXEND] = evt.rx_end; // R4
    set_v[HIF_BIT_TXEND] = evt.tx_end; // R5
    set_v[HIF_BIT_ABORT] = evt.rx_abort; // R6
    set_v[HIF_BIT_TXLOW] = evt.tx_pop & (tx_level == HIF_TX_LOW_LEVEL); // R7
    set_v[HIF_BIT_UNDER] = evt.tx_underrun; // R8
    set_v[HIF_BIT_RXHIGH] = (rx_level >= HIF_RX_HIGH_LEVEL); // R9
    set_v[HIF_BIT_OVF] = ovf_set; // R10
  end

  // A read of the status register clears every flag not being set in the same cycle.
  assign rd_irq = up_rd & (up_addr == HIF_ADDR_IRQ); // R11

  // One sticky flag per interrupt source.
  for (genvar i = 0; i < 8; i++) begin : g_flag
    hif_flag u_flag (
      .clk(clk),
      .nrst(nrst),
      .set(set_v[i]),
      .clr(rd_irq), // R11
      .q(flags_q[i])
    );
  end

  // Summary of enabled pending flags.
  assign pend = |(flags_vis & mask_eff); // R18 R19

  // Interrupt request follows the summary one cycle later.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= pend; // R19
    end
  end

  // Processor reads; status reads return the flags.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (up_rd) begin
      unique case (up_addr)
        HIF_ADDR_STATUS: rdata_q <= {status_upper, pend}; // R18
        HIF_ADDR_IRQ: rdata_q <= flags_vis; // R17
        HIF_ADDR_ARM1: rdata_q <= arm1_q;
        HIF_ADDR_ARM2: rdata_q <= arm2_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // Transmit priority: high when a packet is loaded, low after it ends.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prio_q <= 1'b0;
    end else if (evt.tx_end) begin
      prio_q <= 1'b0; // R5
    end else if (tx_packet_loaded) begin
      prio_q <= 1'b1;
    end
  end

  // Underrun asks the transmitter for an abort sequence.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= evt.tx_underrun; // R8
    end
  end

  // Overflow turns the receiver off until the next flag.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_en_q <= 1'b1;
    end else if (ovf_set) begin
      rx_en_q <= 1'b0; // R10
    end else if (rx_flag_seen) begin
      rx_en_q <= 1'b1; // R10
    end
  end

  // Address comparisons.
  assign cmp1 = addr_recog_enable & arm1_q[HIF_BIT_CMP_EN]; // R13
  assign cmp2 = addr_recog_enable & arm2_q[HIF_BIT_CMP_EN]; // R16
  assign a1_ok = !cmp1 || (rx_in.data[7:2] == arm1_q[7:2]); // R12
  assign a2_ok = (rx_in.data[7:1] == HIF_BROADCAST) // R15
    || (rx_in.data[7:1] == arm2_q[7:1]); // R14

  // Input stalls while the buffer is full or a replay is due.
  assign rx_in_ready = buf_ready & ~replay_q;
  assign take = rx_in_valid & rx_in_ready;

  // Filter state: bytes taken while the receiver is off are dropped.
  always_comb begin
    st_d = st_q;
    if (take && rx_en_q) begin
      if (rx_in.first) begin
        if (!a1_ok) begin
          st_d = ST_DROP; // R12
        end else if (cmp2) begin
          st_d = ST_ADDR2; // R14
        end else begin
          st_d = ST_PASS; // R16
        end
      end else begin
        unique case (st_q)
          ST_ADDR2: st_d = a2_ok ? ST_PASS : ST_DROP; // R14 R15
          ST_PASS: st_d = ST_PASS;
          ST_DROP: st_d = ST_DROP;
          ST_ADDR1: st_d = ST_ADDR1;
        endcase
      end
      if (rx_in.last) begin
        st_d = ST_ADDR1;
      end
    end
  end

  // Filter state register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_ADDR1;
    end else begin
      st_q <= st_d;
    end
  end

  // Words offered to the buffer.
  always_comb begin
    push_v = 1'b0;
    push_b = rx_in;
    if (replay_q) begin
      push_v = 1'b1;
      push_b = hold2_q;
    end else if (take && rx_en_q) begin
      if (rx_in.first) begin
        push_v = a1_ok & ~cmp2; // R12 R13
      end else if (st_q == ST_ADDR2) begin
        push_v = a2_ok; // R14 R15
        push_b = hold1_q;
      end else begin
        push_v = (st_q == ST_PASS);
      end
    end
  end

  // First byte held back until the second is judged.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold1_q <= '0;
    end else if (take && rx_in.first) begin
      hold1_q <= rx_in;
    end
  end

  // Accepted second byte follows its first byte one push later.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      replay_q <= 1'b0;
      hold2_q <= '0;
    end else if (replay_q) begin
      replay_q <= ~buf_ready;
    end else if (take && rx_en_q && !rx_in.first && st_q == ST_ADDR2 && a2_ok) begin
      replay_q <= 1'b1;
      hold2_q <= rx_in;
    end
  end

  // Two-entry output buffer.
  hif_buf2 #(
    .W($bits(hif_byte_type))
  ) u_buf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push_v),
    .in_ready(buf_ready),
    .in_data(push_b),
    .out_valid(rx_out_valid),
    .out_ready(rx_out_ready),
    .out_data(rx_out)
  );

  assign up_rdata = rdata_q;
  assign irq = irq_q;
  assign rx_enable = rx_en_q;
  assign tx_prio_high = prio_q;
  assign tx_abort = abort_q;

  // Checks of the register port, flags and address filter.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_first_bad;
    take && rx_en_q && rx_in.first && cmp1 && (rx_in.data[7:2] != arm1_q[7:2])
      && !rx_in.last;
  endsequence

  sequence s_second_seen;
    take && rx_en_q && !rx_in.first && st_q == ST_ADDR2 && !rx_in.last;
  endsequence

  AST_MASK_WR: assert property (up_wr && up_addr == HIF_ADDR_IRQ // R1
    |=> mask_q == $past(up_wdata)) else $error("Mask not written.");
  AST_COLL_GATE: assert property (!te_mode && (flags_q & mask_q & 8'h7f) == 8'h00 // R2
    |-> !pend) else $error("Collision enable used outside terminal mode.");
  AST_COLL_SET: assert property (coll_set |=> flags_vis[HIF_BIT_COLL] || !te_mode) // R3
    else $error("Collision not flagged.");
  AST_COLL_NT: assert property (up_rd && up_addr == HIF_ADDR_IRQ && !te_mode // R3
    |=> !up_rdata[HIF_BIT_COLL]) else $error("Collision read as one in NT.");
  AST_RXEND: assert property (evt.rx_end |=> flags_q[HIF_BIT_RXEND]) // R4
    else $error("Receive end not flagged.");
  AST_TXEND: assert property (evt.tx_end |=> flags_q[HIF_BIT_TXEND] && !tx_prio_high) // R5
    else $error("Transmit end not flagged.");
  AST_ABORT: assert property (evt.rx_abort |=> flags_q[HIF_BIT_ABORT]) // R6
    else $error("Abort not flagged.");
  AST_TXLOW: assert property (!evt.tx_pop && !flags_q[HIF_BIT_TXLOW] // R7
    |=> !flags_q[HIF_BIT_TXLOW]) else $error("Low flag without draining.");
  AST_UNDER: assert property (evt.tx_underrun |=> flags_q[HIF_BIT_UNDER] && tx_abort // R8
    ##1 !tx_abort || $past(evt.tx_underrun)) else $error("Underrun handling wrong.");
  AST_RXHIGH: assert property (rx_level >= HIF_RX_HIGH_LEVEL // R9
    |=> flags_q[HIF_BIT_RXHIGH]) else $error("High flag missing.");
  AST_OVF: assert property (ovf_set |=> flags_q[HIF_BIT_OVF] && !rx_enable) // R10
    else $error("Overflow handling wrong.");
  AST_RDCLR: assert property (rd_irq && set_v == 8'h00 |=> flags_q == 8'h00) // R11
    else $error("Status read did not clear.");
  AST_DROP: assert property (s_first_bad |=> st_q == ST_DROP) // R12
    else $error("Mismatching first byte not dropped.");
  AST_NO_CMP1: assert property (take && rx_en_q && rx_in.first && !cmp1 && !cmp2 // R13
    |-> push_v) else $error("First byte filtered while compare off.");
  AST_SECOND: assert property (s_second_seen ##0 a2_ok |=> replay_q) // R14 R15
    else $error("Accepted second byte not replayed.");
  AST_NO_CMP2: assert property (take && rx_en_q && rx_in.first && a1_ok && !cmp2 // R16
    |=> st_q != ST_ADDR2) else $error("Second byte held while compare off.");
  AST_READ_ROUTE: assert property (rd_irq |=> up_rdata == $past(flags_vis)) // R17
    else $error("Status read returned wrong data.");
  AST_SUMMARY: assert property (up_rd && up_addr == HIF_ADDR_STATUS // R18
    |=> up_rdata[0] == $past(pend)) else $error("Summary bit wrong.");
  AST_IRQ: assert property (pend |=> irq) // R19
    else $error("Interrupt request missing.");

endmodule : hif_top

// File: inc/hif_pkg.sv
// Function
// [R1] Eight-bit enable mask, one bit per flag.
// [R2] Collision enable counts only in terminal mode.
// [R3] Collision flag on echo mismatch; zero in NT.
// [R4] Receive packet end sets receive end flag.
// [R5] Closing flag sent sets flag, drops priority.
// [R6] Receive abort sequence sets abort flag.
// [R7] Four bytes left while draining sets low flag.
// [R8] Untagged empty sets underrun, sends abort sequence.
// [R9] Fifteen or more received bytes sets high flag.
// [R10] Byte into full FIFO: overflow, receiver off.
// [R11] Status read clears every interrupt flag; a flag set in the same cycle as the read stays set.
// [R12] First address byte compared against six-bit mask.
// [R13] First-byte compare off skips first byte.
// [R14] Second address byte compared against seven-bit mask.
// [R15] All-ones second byte is broadcast, always accepted.
// [R16] Second-byte compare off skips second byte.
// [R17] Mask written, status read, same address.
// [R18] Status register summary bit shows pending interrupt.
// [R19] Interrupt request follows enabled pending flags.
package hif_pkg;

  // Register port addresses.
  localparam logic [4:0] HIF_ADDR_STATUS = 5'h03;
  localparam logic [4:0] HIF_ADDR_IRQ = 5'h04;
  localparam logic [4:0] HIF_ADDR_ARM1 = 5'h06;
  localparam logic [4:0] HIF_ADDR_ARM2 = 5'h07;

  // Flag and enable bit positions.
  localparam int HIF_BIT_COLL = 7;
  localparam int HIF_BIT_RXEND = 6;
  localparam int HIF_BIT_TXEND = 5;
  localparam int HIF_BIT_ABORT = 4;
  localparam int HIF_BIT_TXLOW = 3;
  localparam int HIF_BIT_UNDER = 2;
  localparam int HIF_BIT_RXHIGH = 1;
  localparam int HIF_BIT_OVF = 0;
  localparam int HIF_BIT_CMP_EN = 0;

  // Reset values.
  localparam logic [7:0] HIF_RST_MASK = 8'h00;
  localparam logic [7:0] HIF_RST_ARM = 8'h00;

  // FIFO thresholds and the broadcast address pattern.
  localparam logic [4:0] HIF_TX_LOW_LEVEL = 5'h04;
  localparam logic [4:0] HIF_RX_HIGH_LEVEL = 5'h0f;
  localparam logic [4:0] HIF_FIFO_DEPTH = 5'h13;
  localparam logic [6:0] HIF_BROADCAST = 7'h7f;

  // Events from the HDLC transmitter, receiver and FIFOs.
  typedef struct packed {
    logic echo_valid;
    logic echo_bit;
    logic d_bit;
    logic rx_end;
    logic tx_end;
    logic rx_abort;
    logic tx_pop;
    logic tx_underrun;
    logic rx_push;
  } hif_evt_type;

  // One received byte with its packet position marks.
  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
  } hif_byte_type;

  // Address filter states.
  typedef enum logic [1:0] {
    ST_ADDR1 = 2'b00,
    ST_ADDR2 = 2'b01,
    ST_PASS = 2'b10,
    ST_DROP = 2'b11
  } hif_filt_state_type;

endpackage : hif_pkg

// File: hdl/hif_flag.sv
// One sticky flag; a set in the clearing cycle wins.
module hif_flag (
  input wire logic clk,
  input wire logic nrst,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  // Set has priority over clear so no event is lost.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= 1'b0;
    end else begin
      q <= set | (q & ~clr);
    end
  end

endmodule : hif_flag

// File: hdl/hif_buf2.sv
// Two-entry buffer; a stall at the output loses no word.
module hif_buf2 #(
  parameter int W = 10
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] slot_q [2]; // Storage slots.
  logic wr_q; // Write slot pointer.
  logic rd_q; // Read slot pointer.
  logic [1:0] cnt_q; // Words held.
  logic push; // Word taken in.
  logic pop; // Word handed out.

  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = slot_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Slot storage and pointers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slot_q[0] <= '0;
      slot_q[1] <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      if (push) begin
        slot_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
    end
  end

  // Fill count.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 2'd0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 2'd1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 2'd1;
    end
  end

endmodule : hif_buf2

// File: verif/hif_cpu_model.sv
// Processor side of the register port; strobes move only on falling edges.
module hif_cpu_model (
  input wire logic clk,
  output logic [4:0] up_addr,
  output logic up_wr,
  output logic up_rd,
  output logic [7:0] up_wdata,
  input wire logic [7:0] up_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // The port starts idle, with the data lines showing a pattern of no meaning.
  initial begin
    up_addr = 5'h1f;
    up_wr = 1'b0;
    up_rd = 1'b0;
    up_wdata = 8'h5a;
  end

  // One write: a single strobe cycle, then the data lines are scrambled.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    up_addr = a;
    up_wdata = d;
    up_wr = 1'b1;
    @(negedge clk);
    up_wr = 1'b0;
    up_wdata = ~d;
  endtask : wr

  // One read: the answer is taken one cycle after the strobe edge.
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk);
    up_addr = a;
    up_rd = 1'b1;
    @(negedge clk);
    up_rd = 1'b0;
    d = up_rdata;
  endtask : rd
endmodule : hif_cpu_model

// File: verif/testbench.sv
// Self-checking bench for the interrupt flags, mask and address filter.
module testbench;
  import hif_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, nrst, up_wr, up_rd, te_mode, tx_enable, addr_recog_enable;
  logic tx_packet_loaded, rx_flag_seen, rx_in_valid, rx_in_ready, rx_out_valid;
  logic rx_out_ready = 1'b0; // Driven only by the stall process below.
  logic irq, rx_enable, tx_prio_high, tx_abort;
  logic [4:0] up_addr, tx_level, rx_level;
  logic [7:0] up_wdata, up_rdata, rd_v;
  logic [6:0] status_upper;
  hif_evt_type evt;
  hif_byte_type rx_in, rx_out;
  logic [7:0] got[$]; // Words delivered by the filter.
  int mismatches, n_compared;
  int stall = 0; // Stall pattern counter, owned by the stall process.

  hif_cpu_model cpu (.clk(clk), .up_addr(up_addr), .up_wr(up_wr), .up_rd(up_rd),
    .up_wdata(up_wdata), .up_rdata(up_rdata));
  hif_top dut (.clk(clk), .nrst(nrst), .up_addr(up_addr), .up_wr(up_wr), .up_rd(up_rd),
    .up_wdata(up_wdata), .up_rdata(up_rdata), .te_mode(te_mode), .tx_enable(tx_enable),
    .addr_recog_enable(addr_recog_enable), .evt(evt), .tx_level(tx_level),
    .rx_level(rx_level), .tx_packet_loaded(tx_packet_loaded), .rx_flag_seen(rx_flag_seen),
    .status_upper(status_upper), .rx_in(rx_in), .rx_in_valid(rx_in_valid),
    .rx_in_ready(rx_in_ready), .rx_out(rx_out), .rx_out_valid(rx_out_valid),
    .rx_out_ready(rx_out_ready), .irq(irq), .rx_enable(rx_enable),
    .tx_prio_high(tx_prio_high), .tx_abort(tx_abort));

  // Clock with a 26 ns period: the 12.5 ns half period rounds to 13 ns at 1 ns precision.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The receiver of the filtered stream stalls one cycle in three.
  always @(negedge clk) begin
    stall <= (stall + 1) % 3;
    rx_out_ready <= (stall != 0);
  end

  // Every word handed over by the filter is recorded.
  always @(posedge clk) begin
    if (rx_out_valid === 1'b1 && rx_out_ready === 1'b1) got.push_back(rx_out.data);
  end

  // Compares one value and reports a mismatch.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // Pulses an event for one cycle and lets flag and request settle.
  task automatic fire(input hif_evt_type e);
    @(negedge clk);
    evt = e;
    @(negedge clk);
    evt = '0;
    repeat (2) @(negedge clk);
  endtask : fire

  // Reads the flags, expects the value and a dropped request afterwards.
  task automatic read_flags(input logic [7:0] exp);
    cpu.rd(HIF_ADDR_IRQ, rd_v);
    check("flags", rd_v, exp);
    repeat (2) @(negedge clk);
    check("irq after read", {7'h00, irq}, 8'h00);
    cpu.rd(HIF_ADDR_IRQ, rd_v);
    check("flags cleared", rd_v, 8'h00);
  endtask : read_flags

  // Sends one byte with its marks, waiting while the filter refuses.
  task automatic send(input logic [7:0] d, input logic f, input logic l);
    int i;
    @(negedge clk);
    rx_in = '{data: d, first: f, last: l};
    rx_in_valid = 1'b1;
    #1;
    for (i = 0; i < 50 && rx_in_ready !== 1'b1; i++) begin
      @(negedge clk);
      #1;
    end
    if (i == 50) begin
      check("rx_in_ready wait", 8'h00, 8'h01);
      finish_test();
    end
    @(negedge clk);
    rx_in_valid = 1'b0;
  endtask : send

  // Register reset values, read back, unmapped read and summary bit.
  task automatic t_regs();
    cpu.rd(HIF_ADDR_ARM1, rd_v);
    check("arm1 reset", rd_v, HIF_RST_ARM);
    check("rx_enable reset", {7'h00, rx_enable}, 8'h01);
    cpu.wr(HIF_ADDR_ARM1, 8'ha9);
    cpu.wr(HIF_ADDR_ARM2, 8'h25);
    cpu.rd(HIF_ADDR_ARM1, rd_v);
    check("arm1", rd_v, 8'ha9);
    cpu.rd(HIF_ADDR_ARM2, rd_v);
    check("arm2", rd_v, 8'h25);
    cpu.rd(5'h1e, rd_v);
    check("unmapped", rd_v, 8'h00);
    cpu.wr(HIF_ADDR_IRQ, 8'hff);
    cpu.rd(HIF_ADDR_IRQ, rd_v);
    check("mask not read back", rd_v, 8'h00);
    cpu.rd(HIF_ADDR_STATUS, rd_v);
    check("status idle", rd_v, 8'haa);
    fire('{rx_end: 1'b1, default: 1'b0});
    check("irq rx end", {7'h00, irq}, 8'h01);
    cpu.rd(HIF_ADDR_STATUS, rd_v);
    check("status pending", rd_v, 8'hab);
    read_flags(8'h40);
  endtask : t_regs

  // Collision is gated by the mode; a disabled source raises no request.
  task automatic t_mask();
    fire('{echo_valid: 1'b1, echo_bit: 1'b1, default: 1'b0});
    check("irq nt coll", {7'h00, irq}, 8'h00);
    cpu.rd(HIF_ADDR_IRQ, rd_v);
    check("coll nt", rd_v, 8'h00);
    te_mode = 1'b1;
    fire('{echo_valid: 1'b1, d_bit: 1'b1, default: 1'b0});
    check("irq te coll", {7'h00, irq}, 8'h01);
    te_mode = 1'b0;
    repeat (2) @(negedge clk);
    check("irq coll in nt", {7'h00, irq}, 8'h00);
    te_mode = 1'b1;
    read_flags(8'h80);
    fire('{echo_valid: 1'b1, d_bit: 1'b1, echo_bit: 1'b1, default: 1'b0});
    cpu.rd(HIF_ADDR_IRQ, rd_v);
    check("echo equal", rd_v, 8'h00);
    tx_enable = 1'b0;
    fire('{echo_valid: 1'b1, d_bit: 1'b1, default: 1'b0});
    cpu.rd(HIF_ADDR_IRQ, rd_v);
    check("coll tx off", rd_v, 8'h00);
    tx_enable = 1'b1;
    cpu.wr(HIF_ADDR_IRQ, 8'hef);
    fire('{rx_abort: 1'b1, default: 1'b0});
    check("irq masked", {7'h00, irq}, 8'h00);
    read_flags(8'h10);
    cpu.wr(HIF_ADDR_IRQ, 8'hff);
  endtask : t_mask

  // Transmit side: low level only while draining, underrun, packet end.
  task automatic t_tx();
    tx_level = HIF_TX_LOW_LEVEL;
    fire('{tx_pop: 1'b0, default: 1'b0});
    tx_level = 5'h05;
    fire('{tx_pop: 1'b1, default: 1'b0});
    cpu.rd(HIF_ADDR_IRQ, rd_v);
    check("no tx low", rd_v, 8'h00);
    tx_level = HIF_TX_LOW_LEVEL;
    fire('{tx_pop: 1'b1, default: 1'b0});
    read_flags(8'h08);
    @(negedge clk);
    evt = '{tx_underrun: 1'b1, default: 1'b0};
    @(negedge clk);
    evt = '0;
    check("tx_abort", {7'h00, tx_abort}, 8'h01);
    @(negedge clk);
    check("tx_abort pulse", {7'h00, tx_abort}, 8'h00);
    read_flags(8'h04);
    @(negedge clk);
    tx_packet_loaded = 1'b1;
    @(negedge clk);
    tx_packet_loaded = 1'b0;
    check("prio high", {7'h00, tx_prio_high}, 8'h01);
    fire('{tx_end: 1'b1, default: 1'b0});
    check("prio low", {7'h00, tx_prio_high}, 8'h00);
    read_flags(8'h20);
  endtask : t_tx

  // Receive FIFO high level, overflow and receiver re-enable on a flag.
  task automatic t_rx();
    rx_level = 5'h0e;
    fire('{rx_push: 1'b1, default: 1'b0});
    cpu.rd(HIF_ADDR_IRQ, rd_v);
    check("below high", rd_v, 8'h00);
    rx_level = HIF_RX_HIGH_LEVEL;
    @(negedge clk);
    rx_level = 5'h00;
    read_flags(8'h02);
    rx_level = HIF_FIFO_DEPTH;
    fire('{rx_push: 1'b1, default: 1'b0});
    rx_level = 5'h00;
    check("rx off", {7'h00, rx_enable}, 8'h00);
    read_flags(8'h03);
    check("rx still off", {7'h00, rx_enable}, 8'h00);
    send(8'h99, 1'b1, 1'b1);
    @(negedge clk);
    rx_flag_seen = 1'b1;
    @(negedge clk);
    rx_flag_seen = 1'b0;
    check("rx on", {7'h00, rx_enable}, 8'h01);
  endtask : t_rx

  // Address filter: match, mismatch on either byte, broadcast, compare off.
  task automatic t_filter();
    logic [7:0] exp[$];
    int i;
    exp = '{8'h04, 8'h30, 8'ha8, 8'h24, 8'h55, 8'ha8, 8'hfe, 8'h55, 8'h00, 8'h11};
    send(8'h04, 1, 0); send(8'h30, 0, 1);
    addr_recog_enable = 1'b1;
    send(8'ha8, 1, 0); send(8'h24, 0, 0); send(8'h55, 0, 1);
    send(8'ha8, 1, 0); send(8'h30, 0, 0); send(8'h66, 0, 1);
    send(8'ha8, 1, 0); send(8'hfe, 0, 0); send(8'h55, 0, 1);
    send(8'h04, 1, 0); send(8'h24, 0, 0); send(8'h77, 0, 1);
    cpu.wr(HIF_ADDR_ARM1, 8'ha8);
    cpu.wr(HIF_ADDR_ARM2, 8'h24);
    send(8'h00, 1, 0); send(8'h11, 0, 1);
    for (i = 0; i < 100 && got.size() < exp.size(); i++) @(negedge clk);
    check("word count", 8'(got.size()), 8'(exp.size()));
    for (i = 0; i < exp.size() && i < got.size(); i++) check("word", got[i], exp[i]);
  endtask : t_filter

  // Main sequence.
  initial begin
    mismatches = 0;
    n_compared = 0;
    nrst = 1'b0;
    te_mode = 1'b0;
    tx_enable = 1'b1;
    addr_recog_enable = 1'b0;
    evt = '0;
    tx_level = 5'h00;
    rx_level = 5'h00;
    tx_packet_loaded = 1'b0;
    rx_flag_seen = 1'b0;
    status_upper = 7'h55;
    rx_in = '0;
    rx_in_valid = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    t_regs();
    t_mask();
    t_tx();
    t_rx();
    t_filter();
    finish_test();
  end
endmodule : testbench
